// ---- common/dtc_pkg.sv ----
/*
 * dtc_pkg: register map, field positions, reset values, modes and bus
 * structs for the dual timer/counter block.
 * assumes a single 10 MHz clock domain and an AHB-Lite register bus.
 */
package dtc_pkg;

    // byte addresses (index times four, since the control-B offset is odd)
    localparam logic [7:0] DTC_IDX_CTRL_B = 8'h91;
    localparam logic [11:0] DTC_ADDR_CTRL_B = {2'b00, DTC_IDX_CTRL_B, 2'b00};
    localparam logic [11:0] DTC_ADDR_CTRL = 12'h000;
    localparam logic [11:0] DTC_ADDR_MODE = 12'h004;
    localparam logic [11:0] DTC_ADDR_CNT_A = 12'h008;
    localparam logic [11:0] DTC_ADDR_CNT_B = 12'h00C;
    localparam logic [11:0] DTC_ADDR_RLD_A = 12'h010;
    localparam logic [11:0] DTC_ADDR_RLD_B = 12'h014;
    localparam logic [11:0] DTC_ADDR_CLK_CFG = 12'h018;
    localparam int DTC_ADDR_W = 12;

    // control register bits
    localparam int DTC_CTRL_RUN_A = 0;
    localparam int DTC_CTRL_OVF_A = 1;
    localparam int DTC_CTRL_RUN_B = 2;
    localparam int DTC_CTRL_OVF_B = 3;

    // mode register fields, per timer nibble
    localparam int DTC_MODE_LO = 0;
    localparam int DTC_SRC_SEL = 2;
    localparam int DTC_GATING = 3;
    localparam int DTC_NIB_B = 4;

    // control-B fields
    localparam int DTC_PSC_A_LSB = 0;
    localparam int DTC_PSC_B_LSB = 3;
    localparam int DTC_PWM_EN_A = 6;
    localparam int DTC_PWM_EN_B = 7;
    localparam logic [7:0] DTC_CTRL_B_RST = 8'h24;

    // clock config: prescale [3:0], double-rate a [4], b [5], fast mode [6]
    localparam int DTC_CFG_TPS_W = 4;
    localparam int DTC_CFG_X2_A = 4;
    localparam int DTC_CFG_X2_B = 5;
    localparam int DTC_CFG_FAST = 6;

    localparam logic [7:0] DTC_BYTE_ZERO = 8'h00;
    localparam logic [7:0] DTC_BYTE_ONES = 8'hFF;
    localparam logic [15:0] DTC_WORD_ZERO = 16'h0000;
    localparam logic [15:0] DTC_WORD_ONES = 16'hFFFF;
    localparam logic [3:0] DTC_TPS_ZERO = 4'h0;

    typedef enum logic [1:0] {
        DTC_MODE_VAR = 2'b00,
        DTC_MODE_R16 = 2'b01,
        DTC_MODE_R8 = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_e;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_pair_s;

    typedef struct packed {
        logic sel;
        logic [1:0] trans;
        logic write;
        logic [2:0] size;
        logic [DTC_ADDR_W-1:0] addr;
    } dtc_ahb_req_s;

endpackage

// ---- design/dtc_unit.sv ----
/*
 * dtc_unit: one timer channel's count step for the mode that is set.
 * assumes the caller masks the enables and applies the results.
 */
`timescale 1ns/10ps
module dtc_unit
    import dtc_pkg::*;
(
    // configuration
    input wire dtc_mode_e mode,
    input wire logic [2:0] psc,
    input wire dtc_pair_s cnt,
    input wire dtc_pair_s rld,
    // steps
    input wire logic step_low,
    input wire logic step_high,
    // results
    output dtc_pair_s nxt_cnt,
    output logic ovf_low,
    output logic ovf_high
);

    logic [7:0] mask;
    logic [7:0] low_act;
    logic [16:0] sum16;

    always_comb begin
        mask = DTC_BYTE_ONES >> (3'd7 - psc);
        low_act = cnt.low & mask;
        sum16 = {1'b0, cnt} + 17'h00001;
        nxt_cnt = cnt;
        ovf_low = 1'b0;
        ovf_high = 1'b0;
        case (mode)
            DTC_MODE_VAR: begin
                // low prescaler carries into high byte
                if (step_low) begin
                    if (low_act == mask) begin
                        nxt_cnt.low = cnt.low & ~mask;
                        nxt_cnt.high = cnt.high + 8'h01;
                        ovf_low = (cnt.high == DTC_BYTE_ONES);
                    end else begin
                        nxt_cnt.low = cnt.low + 8'h01;
                    end
                end
            end
            DTC_MODE_R16: begin
                if (step_low) begin
                    if (sum16[16]) begin
                        nxt_cnt = rld;
                        ovf_low = 1'b1;
                    end else begin
                        nxt_cnt = sum16[15:0];
                    end
                end
            end
            DTC_MODE_R8: begin
                if (step_low) begin
                    if (cnt.low == DTC_BYTE_ONES) begin
                        nxt_cnt.low = cnt.high;
                        ovf_low = 1'b1;
                    end else begin
                        nxt_cnt.low = cnt.low + 8'h01;
                    end
                end
            end
            DTC_MODE_SPLIT: begin
                if (step_low) begin
                    nxt_cnt.low = cnt.low + 8'h01;
                    ovf_low = (cnt.low == DTC_BYTE_ONES);
                end
                if (step_high) begin
                    nxt_cnt.high = cnt.high + 8'h01;
                    ovf_high = (cnt.high == DTC_BYTE_ONES);
                end
            end
            default: begin
                nxt_cnt = cnt;
            end
        endcase
    end

endmodule // dtc_unit

// ---- design/dtc_top.sv ----
/*
 * dtc_top: two timer/counters with mode, control and prescale registers
 * reached over AHB-Lite.
 * assumes synchronous count and gate pins, one 10 MHz clock, and an
 * interrupt controller that pulses the vector-taken inputs.
 */
// The implementer's own choice: the AHB-Lite interface to the registers.
// Operation
// - two-bit field picks one of four modes
// - variable mode: prescaled low feeds high byte
// - active prescaler bits equal field plus one
// - prescaler fields reset to 100 binary
// - thirteen-bit default, upper low bits ignored
// - variable count wrap sets overflow flag
// - count while run and gate satisfied
// - setting run never clears the counts
// - source select at mode bits six, two
// - reload mode counts all sixteen bits
// - sixteen-bit wrap reloads and flags
// - reload registers reset to zero
// - eight-bit mode reloads low from high
// - reload registers free storage in mode two
// - timeouts scale by timer prescale plus one
// - prescale in fast mode only if doubled
// - pulse enable drives count pin out
// - split: timer a high uses b's run, flag
// - timer b in mode three holds
// - flag cleared when vector is taken
`timescale 1ns/10ps
module dtc_top
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // external pins
    input wire logic COUNT_PIN_A_IN,
    input wire logic COUNT_PIN_B_IN,
    input wire logic EXT_GATE_PIN_A,
    input wire logic EXT_GATE_PIN_B,
    output logic COUNT_PIN_A_OE,
    output logic COUNT_PIN_B_OE,
    // interrupt controller
    input wire logic VECTOR_TAKEN_A,
    input wire logic VECTOR_TAKEN_B,
    output logic OVF_FLAG_A,
    output logic OVF_FLAG_B
);

    typedef struct packed {
        dtc_ahb_req_s req;
        logic [7:0] rdata;
        logic run_bit_t0;
        logic run_bit_t1;
        logic ovf_flag_t0;
        logic ovf_flag_t1;
        logic [7:0] timer_mode_reg;
        logic [7:0] timer_control_reg_b;
        logic [7:0] clock_config_reg;
        dtc_pair_s cnt_a;
        dtc_pair_s cnt_b;
        dtc_pair_s rld_a;
        dtc_pair_s rld_b;
        logic [3:0] tps_cnt;
        logic pin_a_q;
        logic pin_b_q;
        logic half_ph;
    } dtc_state_s;

    dtc_state_s st_ff;
    dtc_state_s nxt_st;

    localparam dtc_state_s DTC_ST_RST = '{
        req: '0, rdata: DTC_BYTE_ZERO, run_bit_t0: 1'b0, run_bit_t1: 1'b0,
        ovf_flag_t0: 1'b0, ovf_flag_t1: 1'b0, timer_mode_reg: DTC_BYTE_ZERO,
        timer_control_reg_b: DTC_CTRL_B_RST, clock_config_reg: DTC_BYTE_ZERO,
        cnt_a: DTC_WORD_ZERO, cnt_b: DTC_WORD_ZERO, rld_a: DTC_WORD_ZERO,
        rld_b: DTC_WORD_ZERO, tps_cnt: DTC_TPS_ZERO, pin_a_q: 1'b0, pin_b_q: 1'b0,
        half_ph: 1'b0
    };

    function automatic logic [7:0] reg_read(input dtc_state_s s,
                                            input logic [DTC_ADDR_W-1:0] a);
        logic [7:0] v;
        v = DTC_BYTE_ZERO;
        case (a)
            DTC_ADDR_CTRL: v = {4'h0, s.ovf_flag_t1, s.run_bit_t1,
                                s.ovf_flag_t0, s.run_bit_t0};
            DTC_ADDR_MODE: v = s.timer_mode_reg;
            DTC_ADDR_CTRL_B: v = s.timer_control_reg_b;
            DTC_ADDR_CLK_CFG: v = s.clock_config_reg;
            default: v = DTC_BYTE_ZERO;
        endcase
        return v;
    endfunction

    // write strobe for one register at the latched address phase
    function automatic logic hit(input dtc_state_s s,
                                 input logic [DTC_ADDR_W-1:0] a);
        return s.req.sel && s.req.write && (s.req.addr == a);
    endfunction

    logic wr_phase;
    logic tick;
    logic pin_edge_a;
    logic pin_edge_b;
    logic en_a;
    logic en_b;
    logic en_hi_split;
    dtc_mode_e mode_a;
    dtc_mode_e mode_b;
    dtc_pair_s step_a;
    dtc_pair_s step_b;
    logic ovf_a_low;
    logic ovf_a_high;
    logic ovf_b_low;
    logic split_a;
    logic x2_a;
    logic x2_b;
    logic tick_a;
    logic tick_b;
    logic [31:0] rd_word;
    logic [7:0] mask_a;

    ////////////////////////////////////////////////////////////////////////
    // counting enables

    always_comb begin
        mode_a = dtc_mode_e'(st_ff.timer_mode_reg[DTC_MODE_LO +: 2]);
        mode_b = dtc_mode_e'(st_ff.timer_mode_reg[DTC_NIB_B + DTC_MODE_LO +: 2]);
        split_a = (mode_a == DTC_MODE_SPLIT);
        x2_a = st_ff.clock_config_reg[DTC_CFG_X2_A];
        x2_b = st_ff.clock_config_reg[DTC_CFG_X2_B];
        // at or above, so lowering the prescale never stalls a full wrap
        tick = (st_ff.tps_cnt >= st_ff.clock_config_reg[DTC_CFG_TPS_W-1:0]);
        // fast: prescale only if doubled; compat: doubling halves rate
        tick_a = st_ff.clock_config_reg[DTC_CFG_FAST] ? (!x2_a || tick)
            : (tick && (!x2_a || st_ff.half_ph));
        tick_b = st_ff.clock_config_reg[DTC_CFG_FAST] ? (!x2_b || tick)
            : (tick && (!x2_b || st_ff.half_ph));
        mask_a = DTC_BYTE_ONES >> (3'd7 - st_ff.timer_control_reg_b[DTC_PSC_A_LSB +: 3]);
        pin_edge_a = st_ff.pin_a_q && !COUNT_PIN_A_IN;
        pin_edge_b = st_ff.pin_b_q && !COUNT_PIN_B_IN;
        // select bits at two and six
        en_a = st_ff.run_bit_t0
            && (!st_ff.timer_mode_reg[DTC_GATING] || EXT_GATE_PIN_A)
            && (st_ff.timer_mode_reg[DTC_SRC_SEL] ? pin_edge_a : tick_a);
        en_b = st_ff.run_bit_t1 && (mode_b != DTC_MODE_SPLIT)
            && (!st_ff.timer_mode_reg[DTC_NIB_B + DTC_GATING] || EXT_GATE_PIN_B)
            && (st_ff.timer_mode_reg[DTC_NIB_B + DTC_SRC_SEL] ? pin_edge_b : tick_b);
        // split high byte: clocks, b's run bit
        en_hi_split = split_a && st_ff.run_bit_t1 && tick_a;
    end

    dtc_unit u_unit_a (
        .mode(mode_a),
        .psc(st_ff.timer_control_reg_b[DTC_PSC_A_LSB +: 3]),
        .cnt(st_ff.cnt_a),
        .rld(st_ff.rld_a),
        .step_low(en_a),
        .step_high(en_hi_split),
        .nxt_cnt(step_a),
        .ovf_low(ovf_a_low),
        .ovf_high(ovf_a_high)
    );

    dtc_unit u_unit_b (
        .mode(mode_b),
        .psc(st_ff.timer_control_reg_b[DTC_PSC_B_LSB +: 3]),
        .cnt(st_ff.cnt_b),
        .rld(st_ff.rld_b),
        .step_low(en_b),
        .step_high(1'b0),
        .nxt_cnt(step_b),
        .ovf_low(ovf_b_low),
        .ovf_high()
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        wr_phase = 1'b0;
        nxt_st.pin_a_q = COUNT_PIN_A_IN;
        nxt_st.pin_b_q = COUNT_PIN_B_IN;
        nxt_st.tps_cnt = tick ? DTC_TPS_ZERO : st_ff.tps_cnt + 4'h1;
        nxt_st.half_ph = tick ? !st_ff.half_ph : st_ff.half_ph;
        // counts persist, only steps and count register writes change them
        nxt_st.cnt_a = step_a;
        nxt_st.cnt_b = step_b;

        // address phase capture
        if (HREADY) begin
            nxt_st.req.sel = HSEL && HTRANS[1];
            nxt_st.req.trans = HTRANS;
            nxt_st.req.write = HWRITE;
            nxt_st.req.size = HSIZE;
            nxt_st.req.addr = HADDR[DTC_ADDR_W-1:0];
            nxt_st.rdata = reg_read(st_ff, HADDR[DTC_ADDR_W-1:0]);
        end
        wr_phase = st_ff.req.sel && st_ff.req.write;

        if (wr_phase) begin
            if (hit(st_ff, DTC_ADDR_CTRL)) begin
                nxt_st.run_bit_t0 = HWDATA[DTC_CTRL_RUN_A];
                nxt_st.run_bit_t1 = HWDATA[DTC_CTRL_RUN_B];
                nxt_st.ovf_flag_t0 = HWDATA[DTC_CTRL_OVF_A];
                nxt_st.ovf_flag_t1 = HWDATA[DTC_CTRL_OVF_B];
            end
            if (hit(st_ff, DTC_ADDR_MODE)) begin
                nxt_st.timer_mode_reg = HWDATA[7:0];
            end
            if (hit(st_ff, DTC_ADDR_CTRL_B)) begin
                nxt_st.timer_control_reg_b = HWDATA[7:0];
            end
            if (hit(st_ff, DTC_ADDR_CLK_CFG)) begin
                nxt_st.clock_config_reg = HWDATA[7:0];
            end
            if (hit(st_ff, DTC_ADDR_CNT_A)) begin
                nxt_st.cnt_a = HWDATA[15:0];
            end
            if (hit(st_ff, DTC_ADDR_CNT_B)) begin
                nxt_st.cnt_b = HWDATA[15:0];
            end
            // reload words always read and write
            if (hit(st_ff, DTC_ADDR_RLD_A)) begin
                nxt_st.rld_a = HWDATA[15:0];
            end
            if (hit(st_ff, DTC_ADDR_RLD_B)) begin
                nxt_st.rld_b = HWDATA[15:0];
            end
        end

        if (VECTOR_TAKEN_A) begin
            nxt_st.ovf_flag_t0 = 1'b0;
        end
        if (VECTOR_TAKEN_B) begin
            nxt_st.ovf_flag_t1 = 1'b0;
        end
        // set wins over any clear
        if (ovf_a_low) begin
            nxt_st.ovf_flag_t0 = 1'b1;
        end
        // split high byte owns b's flag
        if (split_a ? ovf_a_high : ovf_b_low) begin
            nxt_st.ovf_flag_t1 = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff <= DTC_ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        rd_word = {24'h000000, st_ff.rdata};
        case (st_ff.req.addr)
            DTC_ADDR_CNT_A: rd_word = {16'h0000, st_ff.cnt_a};
            DTC_ADDR_CNT_B: rd_word = {16'h0000, st_ff.cnt_b};
            DTC_ADDR_RLD_A: rd_word = {16'h0000, st_ff.rld_a};
            DTC_ADDR_RLD_B: rd_word = {16'h0000, st_ff.rld_b};
            default: rd_word = {24'h000000, st_ff.rdata};
        endcase
    end

    // counts read live in the data phase so the value is current
    assign HRDATA = rd_word;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign COUNT_PIN_A_OE = st_ff.timer_control_reg_b[DTC_PWM_EN_A];
    assign COUNT_PIN_B_OE = st_ff.timer_control_reg_b[DTC_PWM_EN_B];
    assign OVF_FLAG_A = st_ff.ovf_flag_t0;
    assign OVF_FLAG_B = st_ff.ovf_flag_t1;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_r16_wrap_a;
        en_a && mode_a == DTC_MODE_R16 && st_ff.cnt_a == DTC_WORD_ONES && !wr_phase;
    endsequence

    AST_R16_RELOAD: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        s_r16_wrap_a |=> (st_ff.cnt_a == $past(st_ff.rld_a)) && st_ff.ovf_flag_t0)
        else $error("sixteen-bit reload missed");

    AST_R8_HOLD_HIGH: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (en_a && mode_a == DTC_MODE_R8 && !wr_phase)
        |=> st_ff.cnt_a.high == $past(st_ff.cnt_a.high))
        else $error("eight-bit mode changed high byte");

    AST_RUN_OFF_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (!st_ff.run_bit_t0 && !split_a && !wr_phase) |=> $stable(st_ff.cnt_a))
        else $error("timer a counted while stopped");

    AST_B_MODE3_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (mode_b == DTC_MODE_SPLIT && !wr_phase) |=> $stable(st_ff.cnt_b))
        else $error("timer b counted in mode three");

    AST_VAR_OVF: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (en_a && mode_a == DTC_MODE_VAR && st_ff.cnt_a.high == DTC_BYTE_ONES && !wr_phase
         && (st_ff.cnt_a.low & mask_a) == mask_a)
        |=> st_ff.ovf_flag_t0 && st_ff.cnt_a.high == DTC_BYTE_ZERO)
        else $error("variable wrap without flag");

    AST_GATE_LOW: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (st_ff.timer_mode_reg[DTC_GATING] && !EXT_GATE_PIN_A) |-> !en_a)
        else $error("gated timer enabled");

    AST_PIN_OE: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (wr_phase && st_ff.req.addr == DTC_ADDR_CTRL_B)
        |=> COUNT_PIN_B_OE == $past(HWDATA[DTC_PWM_EN_B]))
        else $error("pin enable mismatch");

    AST_VECTOR_CLR: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (VECTOR_TAKEN_A && !ovf_a_low && !wr_phase) |=> !OVF_FLAG_A)
        else $error("flag not cleared by vector");

    AST_WRITE_WINS: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (wr_phase && st_ff.req.addr == DTC_ADDR_CNT_B)
        |=> st_ff.cnt_b == $past(HWDATA[15:0]))
        else $error("count write lost");

endmodule // dtc_top

// ---- testbench/dtc_pin_model.sv ----
/*
 * dtc_pin_model: drives the count and gate pins that face the timers.
 * assumes the block samples both pins on the rising clock edge.
 */
`timescale 1ns/10ps
module dtc_pin_model (
    // clock
    input wire logic clk,
    // pins toward the block
    output logic cnt_a,
    output logic cnt_b,
    output logic gate_a,
    output logic gate_b
);
    initial begin
        cnt_a = 1'b1;
        cnt_b = 1'b1;
        gate_a = 1'b0;
        gate_b = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // gate high window
    // n edges see the gate high, so n steps at most
    task automatic gate_burst(input logic b, input int n);
        @(posedge clk);
        if (b) begin
            gate_b <= 1'b1;
        end else begin
            gate_a <= 1'b1;
        end
        repeat (n) @(posedge clk);
        gate_a <= 1'b0;
        gate_b <= 1'b0;
    endtask
    task automatic pin_events(input logic b, input int k);
        repeat (k) begin
            @(posedge clk);
            if (b) begin
                cnt_b <= 1'b0;
            end else begin
                cnt_a <= 1'b0;
            end
            @(posedge clk);
            cnt_a <= 1'b1;
            cnt_b <= 1'b1;
        end
    endtask
endmodule // dtc_pin_model

// ---- testbench/dtc_top_tb.sv ----
/*
 * dtc_top_tb: self-checking bench for the dual timer block.
 * assumes zero-wait AHB-Lite answers and synchronous pins.
 */
`timescale 1ns/10ps
module dtc_top_tb;
    import dtc_pkg::*;
    logic clk, rstn, hsel, hwrite, vta, vtb, rd_dp, pin_chk;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready, hresp, ovf_a, ovf_b, oe_a, oe_b, cpa, cpb, gpa, gpb;
    wire logic [31:0] hrdata;
    int n_mismatch, total_checks, x, n, k;
    logic [7:0] lo;
    logic [32:0] rd_q[$];
    logic [3:0] pin_q[$];

    dtc_top i_dtc_top (.CORE_CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .COUNT_PIN_A_IN(cpa), .COUNT_PIN_B_IN(cpb), .EXT_GATE_PIN_A(gpa),
        .EXT_GATE_PIN_B(gpb), .COUNT_PIN_A_OE(oe_a), .COUNT_PIN_B_OE(oe_b),
        .VECTOR_TAKEN_A(vta), .VECTOR_TAKEN_B(vtb), .OVF_FLAG_A(ovf_a),
        .OVF_FLAG_B(ovf_b));
    dtc_pin_model i_dtc_pin_model (.clk(clk), .cnt_a(cpa), .cnt_b(cpb),
        .gate_a(gpa), .gate_b(gpb));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected hresp_hrdata: expected %h seen %h", e, s);
        end
    endtask
    task automatic cmp_pin(input logic [3:0] e, input logic [3:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected flags_oe: expected %b seen %b", e, s);
        end
    endtask
    // one transfer; waits for hready at each phase, only the watchdog bounds it
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h00000, a};
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= ~w;
        do @(posedge clk); while (hready !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back({1'b0, e});
        xfer(1'b0, a, 32'h00000000);
    endtask
    task automatic pins(input logic [3:0] e);
        pin_q.push_back(e);
        @(posedge clk);
        pin_chk <= 1'b1;
        @(posedge clk);
        pin_chk <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (rd_dp === 1'b1 && hready === 1'b1) cmp_rd(rd_q.pop_front(), {hresp, hrdata});
        if (pin_chk === 1'b1) cmp_pin(pin_q.pop_front(), {ovf_a, ovf_b, oe_a, oe_b});
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rstn, hsel, hwrite, vta, vtb, rd_dp, pin_chk} = 7'h00;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        void'($urandom(27));
        rd(DTC_ADDR_CTRL_B, 32'h00000024);
        rd(DTC_ADDR_RLD_A, 32'h00000000);
        rd(DTC_ADDR_MODE, 32'h00000000);
        rd(12'h0FC, 32'h00000000);
        pins(4'h0);
        wr(DTC_ADDR_RLD_A, 32'h00001234);
        wr(DTC_ADDR_CNT_A, 32'h0000FFFE);
        wr(DTC_ADDR_MODE, 32'h00000009);
        wr(DTC_ADDR_CTRL, 32'h00000001);
        rd(DTC_ADDR_CNT_A, 32'h0000FFFE);
        i_dtc_pin_model.gate_burst(1'b0, 3);
        rd(DTC_ADDR_CNT_A, 32'h00001235);
        rd(DTC_ADDR_CTRL, 32'h00000003);
        @(posedge clk);
        vta <= 1'b1;
        @(posedge clk);
        vta <= 1'b0;
        pins(4'h0);
        repeat (3) begin
            x = $urandom_range(32'h0000FF00, 0);
            n = $urandom_range(20, 1);
            wr(DTC_ADDR_CNT_A, 32'(x));
            i_dtc_pin_model.gate_burst(1'b0, n);
            rd(DTC_ADDR_CNT_A, 32'(x + n));
        end
        // fast mode, double bit clear: prescale bypassed
        wr(DTC_ADDR_CLK_CFG, 32'h00000043);
        wr(DTC_ADDR_CNT_A, 32'h00000000);
        i_dtc_pin_model.gate_burst(1'b0, 5);
        rd(DTC_ADDR_CNT_A, 32'h00000005);
        wr(DTC_ADDR_CLK_CFG, 32'h00000000);
        wr(DTC_ADDR_MODE, 32'h00000008);
        for (int p = 0; p < 8; p++) begin
            lo = 8'hFF >> (7 - p);
            wr(DTC_ADDR_CTRL_B, {24'h000000, 5'b00100, 3'(p)});
            wr(DTC_ADDR_CTRL, 32'h00000001);
            wr(DTC_ADDR_CNT_A, {16'h0000, 8'hFF, lo});
            i_dtc_pin_model.gate_burst(1'b0, 1);
            rd(DTC_ADDR_CNT_A, 32'h00000000);
            pins(4'b1000);
        end
        wr(DTC_ADDR_MODE, 32'h000000A0);
        wr(DTC_ADDR_CNT_B, 32'h0000F0FE);
        wr(DTC_ADDR_RLD_B, 32'h0000BEEF);
        wr(DTC_ADDR_CTRL, 32'h00000004);
        i_dtc_pin_model.gate_burst(1'b1, 3);
        rd(DTC_ADDR_CNT_B, 32'h0000F0F1);
        rd(DTC_ADDR_RLD_B, 32'h0000BEEF);
        pins(4'b0100);
        wr(DTC_ADDR_MODE, 32'h00000050);
        wr(DTC_ADDR_CNT_B, 32'h00000010);
        k = $urandom_range(9, 1);
        i_dtc_pin_model.pin_events(1'b1, k);
        rd(DTC_ADDR_CNT_B, 32'(16 + k));
        wr(DTC_ADDR_MODE, 32'h00000070);
        i_dtc_pin_model.pin_events(1'b1, 4);
        rd(DTC_ADDR_CNT_B, 32'(16 + k));
        // timer a eight-bit reload, compat mode doubled: every other clock
        wr(DTC_ADDR_CLK_CFG, 32'h00000010);
        wr(DTC_ADDR_MODE, 32'h0000007A);
        wr(DTC_ADDR_CNT_A, 32'h000080FE);
        wr(DTC_ADDR_CTRL, 32'h00000001);
        i_dtc_pin_model.gate_burst(1'b0, 6);
        rd(DTC_ADDR_CNT_A, 32'h00008081);
        pins(4'b1000);
        // split: low byte gated by pin a, high byte on b's run bit
        wr(DTC_ADDR_CLK_CFG, 32'h00000000);
        wr(DTC_ADDR_MODE, 32'h0000007B);
        wr(DTC_ADDR_CNT_A, 32'h000020FE);
        wr(DTC_ADDR_CTRL, 32'h00000001);
        i_dtc_pin_model.gate_burst(1'b0, 3);
        rd(DTC_ADDR_CNT_A, 32'h00002001);
        pins(4'b1000);
        wr(DTC_ADDR_CNT_A, 32'h0000FF01);
        wr(DTC_ADDR_CTRL, 32'h00000004);
        pins(4'b0100);
        @(posedge clk);
        vtb <= 1'b1;
        @(posedge clk);
        vtb <= 1'b0;
        pins(4'b0000);
        wr(DTC_ADDR_CTRL, 32'h00000000);
        wr(DTC_ADDR_CTRL_B, 32'h000000E4);
        pins(4'b0011);
        wr(DTC_ADDR_CTRL_B, 32'h00000024);
        pins(4'b0000);
        repeat (5) @(posedge clk);
        // notes left over mean a result never showed up
        if (rd_q.size() != 0 || pin_q.size() != 0) n_mismatch++;
        wrap_up;
    end
endmodule // dtc_top_tb
